//--- common/arph_pkg.sv
// Contract
// - both ends: 9600 baud 8N1, fixed
// - only controller starts; target only replies
// - packet bytes are printable ASCII below 127
// - target answers every packet addressed to it; code sends no reply when a code, qualifier or argument byte is malformed
// - request starts '<', reply starts '>'
// - start characters never in body; restart packet
// - target address is modem address plus one
// - reply carries the same address as request
// - instruction code: three upper-case letters
// - controller qualifier is only '=' or '?'
// - '=' sets the named parameter
// - '?' reports the named parameter
// - reply qualifier only '=', '?', '!', '*'
// - query reply: code, '=', current value
// - accepted set: code and '=' only
// - invalid argument: code and '?' only
// - change not allowed: code and '*'
// - unknown code: echo code then '!'
// - arguments: digits, period or comma only
// - request ends CR; reply ends CR LF
// - controller forces address, reads factory settings
// - modem relays computer packets and replies
`default_nettype none
package arph_pkg;
    localparam int unsigned CLK_HZ   = 20_000_000;
    localparam int unsigned BAUD     = 9600;
    localparam int unsigned BIT_CYC  = CLK_HZ / BAUD;
    localparam int unsigned HALF_CYC = BIT_CYC / 2;
    localparam int unsigned DATA_BITS = 8;
    localparam logic [7:0] CH_SOP_REQ = 8'h3C;
    localparam logic [7:0] CH_SOP_RSP = 8'h3E;
    localparam logic [7:0] CH_SLASH   = 8'h2F;
    localparam logic [7:0] CH_EQ      = 8'h3D;
    localparam logic [7:0] CH_QRY     = 8'h3F;
    localparam logic [7:0] CH_BANG    = 8'h21;
    localparam logic [7:0] CH_STAR    = 8'h2A;
    localparam logic [7:0] CH_CR      = 8'h0D;
    localparam logic [7:0] CH_LF      = 8'h0A;
    localparam logic [7:0] CH_DOT     = 8'h2E;
    localparam logic [7:0] CH_COMMA   = 8'h2C;
    localparam logic [7:0] CH_ZERO    = 8'h30;
    localparam logic [7:0] CH_NINE    = 8'h39;
    localparam logic [7:0] CH_UPA     = 8'h41;
    localparam logic [7:0] CH_UPZ     = 8'h5A;
    localparam logic [7:0] CH_LIMIT   = 8'h7F;
    localparam int unsigned ADDR_DIG  = 4;
    localparam int unsigned CODE_LEN  = 3;
    localparam int unsigned N_PARAM   = 6;
    localparam int unsigned MAX_ARG   = 7;
    localparam logic [23:0] CODE_TAB [N_PARAM] = '{24'h5546_51, 24'h4446_51, 24'h5541_54,
                                                   24'h4441_54, 24'h5245_46, 24'h5350_41};
    localparam logic [3:0] ARG_LEN [N_PARAM] = '{4'h7, 4'h7, 4'h4, 4'h4, 4'h3, 4'h3};
    localparam logic [7:0] VAL_RST = CH_ZERO;
    localparam int unsigned RPY_FIXED = 12;
endpackage
`default_nettype wire

//--- common/arph_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface arph_link_if;
    logic c2tLine;
    logic t2cLine;
    modport targetEnd
    (
        input  c2tLine,
        output t2cLine
    );
    modport ctrlEnd
    (
        output c2tLine,
        input  t2cLine
    );
endinterface
`default_nettype wire

//--- rtl/arph_target.sv
`timescale 1ns/1ps
`default_nettype none
module arph_uart_rx
    import arph_pkg::*;
#(
    parameter int unsigned BITC = arph_pkg::BIT_CYC
)
(
    input  wire logic       mclk,
    input  wire logic       rstn,
    input  wire logic       line,
    output logic [7:0]      data,
    output logic            valid
);
    logic        s1_ff, s2_ff, busy_ff, valid_ff;
    logic [15:0] tick_ff;
    logic [3:0]  bit_ff;
    logic [7:0]  shf_ff, data_ff;
    wire         tickEnd = (tick_ff == 16'(BITC - 1));
    generate
        if (BITC < 4 || BITC > 65535)
            $error("bit period out of range");
    endgenerate
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            s1_ff <= 1'b1;
            s2_ff <= 1'b1;
        end
        else
        begin
            s1_ff <= line;
            s2_ff <= s1_ff;
        end
    end
    // start at half a bit so every later sample lands mid-bit
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            busy_ff  <= 1'b0;
            tick_ff  <= 16'h0000;
            bit_ff   <= 4'h0;
            shf_ff   <= 8'h00;
            data_ff  <= 8'h00;
            valid_ff <= 1'b0;
        end
        else
        begin
            valid_ff <= 1'b0;
            if (!busy_ff)
            begin
                if (!s2_ff)
                begin
                    busy_ff <= 1'b1;
                    tick_ff <= 16'(BITC / 2);
                    bit_ff  <= 4'h0;
                end
            end
            else if (tickEnd)
            begin
                tick_ff <= 16'h0000;
                bit_ff  <= bit_ff + 4'h1;
                if (bit_ff == 4'h0 && s2_ff)
                    busy_ff <= 1'b0;
                else if (bit_ff >= 4'h1 && bit_ff <= 4'h8)
                    shf_ff <= {s2_ff, shf_ff[7:1]};
                else if (bit_ff == 4'h9)
                begin
                    busy_ff  <= 1'b0;
                    data_ff  <= shf_ff;
                    valid_ff <= s2_ff;
                end
            end
            else
                tick_ff <= tick_ff + 16'h0001;
        end
    end
    assign data  = data_ff;
    assign valid = valid_ff;
endmodule

module arph_uart_tx
    import arph_pkg::*;
#(
    parameter int unsigned BITC = arph_pkg::BIT_CYC
)
(
    input  wire logic       mclk,
    input  wire logic       rstn,
    input  wire logic [7:0] data,
    input  wire logic       valid,
    output logic            ready,
    output logic            line
);
    logic [15:0] tick_ff;
    logic [3:0]  bit_ff;
    logic [9:0]  shf_ff;
    logic        busy_ff, line_ff;
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            busy_ff <= 1'b0;
            tick_ff <= 16'h0000;
            bit_ff  <= 4'h0;
            shf_ff  <= 10'h3FF;
            line_ff <= 1'b1;
        end
        else if (!busy_ff)
        begin
            if (valid)
            begin
                busy_ff <= 1'b1;
                shf_ff  <= {1'b1, data, 1'b0};
                tick_ff <= 16'h0000;
                bit_ff  <= 4'h0;
            end
        end
        else
        begin
            line_ff <= shf_ff[0];
            if (tick_ff == 16'(BITC - 1))
            begin
                tick_ff <= 16'h0000;
                shf_ff  <= {1'b1, shf_ff[9:1]};
                bit_ff  <= bit_ff + 4'h1;
                if (bit_ff == 4'h9)
                    busy_ff <= 1'b0;
            end
            else
                tick_ff <= tick_ff + 16'h0001;
        end
    end
    assign ready = !busy_ff;
    assign line  = line_ff;
endmodule

module arph_target
    import arph_pkg::*;
#(
    parameter int unsigned BITC = arph_pkg::BIT_CYC
)
(
    input  wire logic                    mclk,
    input  wire logic                    rstn,
    arph_link_if.targetEnd               link,
    input  wire logic [arph_pkg::ADDR_DIG*8-1:0] ownAddr,
    input  wire logic                    paramLock,
    output logic                         setPulse,
    output logic [2:0]                   setIndex
);
    import arph_pkg::*;
    typedef enum logic [2:0] {ST_HUNT, ST_ADDR, ST_SLASH, ST_CODE, ST_QUAL, ST_ARGS, ST_REPLY} arph_tst_t;
    arph_tst_t  st_ff;
    logic [7:0] rxByte, txByte;
    logic       rxValid, txReady, txLine;
    logic [2:0] cnt_ff, hit_ff;
    logic       addrOk_ff, isSet_ff, argBad_ff, codeHit, setPulse_ff;
    logic [23:0] code_ff;
    logic [7:0] qualOut_ff;
    logic [3:0] argN_ff, rpyArgs_ff;
    // longest reply is 19 bytes, so the index needs five bits
    logic [4:0] txIdx_ff;
    logic [2:0] hitIdx, setIndex_ff;
    logic [7:0] argBuf_ff [MAX_ARG];
    logic [7:0] valMem_ff [N_PARAM][MAX_ARG];

    arph_uart_rx #(.BITC(BITC)) uRx (.mclk(mclk), .rstn(rstn), .line(link.c2tLine), .data(rxByte),
                                     .valid(rxValid));
    arph_uart_tx #(.BITC(BITC)) uTx (.mclk(mclk), .rstn(rstn), .data(txByte), .valid(st_ff == ST_REPLY),
                      .ready(txReady), .line(txLine));
    assign link.t2cLine = txLine;

    wire isReqStart = (rxByte == CH_SOP_REQ);
    wire isRspStart = (rxByte == CH_SOP_RSP);
    wire isDigit    = (rxByte >= CH_ZERO) && (rxByte <= CH_NINE);
    wire isUpper    = (rxByte >= CH_UPA) && (rxByte <= CH_UPZ);
    wire isArg      = isDigit || rxByte == CH_DOT || rxByte == CH_COMMA;
    wire notAscii   = (rxByte >= CH_LIMIT);
    wire addrMatch  = (rxByte == ownAddr[(ADDR_DIG-1-cnt_ff)*8 +: 8]);
    wire [3:0] expLen = ARG_LEN[hit_ff];
    wire lastTx     = (txIdx_ff == 5'(RPY_FIXED - 1) + 5'(rpyArgs_ff));

    always_comb
    begin
        codeHit = 1'b0;
        hitIdx  = 3'h0;
        for (int i = 0; i < N_PARAM; i++)
            if (code_ff == CODE_TAB[i])
            begin
                codeHit = 1'b1;
                hitIdx  = 3'(i);
            end
    end

    // reply assembled by position so no byte buffer is needed
    always_comb
    begin
        txByte = CH_LF;
        if (txIdx_ff == 5'h00)
            txByte = CH_SOP_RSP;
        else if (txIdx_ff <= 5'(ADDR_DIG))
            txByte = ownAddr[(ADDR_DIG-txIdx_ff)*8 +: 8];
        else if (txIdx_ff == 5'h05)
            txByte = CH_SLASH;
        else if (txIdx_ff <= 5'h08)
            txByte = code_ff[(8-txIdx_ff)*8 +: 8];
        else if (txIdx_ff == 5'h09)
            txByte = qualOut_ff;
        else if (txIdx_ff < 5'h0A + 5'(rpyArgs_ff))
            txByte = valMem_ff[hit_ff][3'(txIdx_ff - 5'h0A)];
        else if (txIdx_ff == 5'h0A + 5'(rpyArgs_ff))
            txByte = CH_CR;
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_ff       <= ST_HUNT;
            cnt_ff      <= 3'h0;
            addrOk_ff   <= 1'b0;
            code_ff     <= 24'h0000_00;
            isSet_ff    <= 1'b0;
            argBad_ff   <= 1'b0;
            argN_ff     <= 4'h0;
            hit_ff      <= 3'h0;
            qualOut_ff  <= CH_EQ;
            rpyArgs_ff  <= 4'h0;
            txIdx_ff    <= 5'h00;
            setPulse_ff <= 1'b0;
            setIndex_ff <= 3'h0;
            for (int i = 0; i < MAX_ARG; i++)
            begin
                argBuf_ff[i] <= VAL_RST;
                for (int p = 0; p < N_PARAM; p++)
                    valMem_ff[p][i] <= VAL_RST;
            end
        end
        else
        begin
            setPulse_ff <= 1'b0;
            if (st_ff == ST_REPLY)
            begin
                if (txReady)
                begin
                    txIdx_ff <= txIdx_ff + 5'h01;
                    if (lastTx)
                        st_ff <= ST_HUNT;
                end
            end
            else if (rxValid)
            begin
                cnt_ff <= 3'h0;
                if (isReqStart)
                begin
                    st_ff     <= ST_ADDR;
                    addrOk_ff <= 1'b1;
                    argN_ff   <= 4'h0;
                    argBad_ff <= 1'b0;
                end
                else if (isRspStart || notAscii)
                    st_ff <= ST_HUNT;
                else
                begin
                    unique case (st_ff)
                        ST_HUNT:  st_ff <= ST_HUNT;
                        ST_ADDR:
                        begin
                            cnt_ff    <= cnt_ff + 3'h1;
                            addrOk_ff <= addrOk_ff && addrMatch;
                            if (!isDigit)
                                st_ff <= ST_HUNT;
                            else if (cnt_ff == 3'(ADDR_DIG - 1))
                                st_ff <= ST_SLASH;
                        end
                        ST_SLASH: st_ff <= (rxByte == CH_SLASH) ? ST_CODE : ST_HUNT;
                        ST_CODE:
                        begin
                            cnt_ff  <= cnt_ff + 3'h1;
                            code_ff <= {code_ff[15:0], rxByte};
                            if (!isUpper)
                                st_ff <= ST_HUNT;
                            else if (cnt_ff == 3'(CODE_LEN - 1))
                                st_ff <= ST_QUAL;
                        end
                        ST_QUAL:
                        begin
                            isSet_ff <= (rxByte == CH_EQ);
                            hit_ff   <= hitIdx;
                            st_ff    <= (rxByte == CH_EQ || rxByte == CH_QRY) ? ST_ARGS : ST_HUNT;
                            if (!codeHit)
                                hit_ff <= 3'h0;
                        end
                        ST_ARGS:
                        begin
                            if (isArg)
                            begin
                                if (argN_ff < 4'(MAX_ARG))
                                begin
                                    argBuf_ff[argN_ff[2:0]] <= rxByte;
                                    argN_ff <= argN_ff + 4'h1;
                                end
                                else
                                    argBad_ff <= 1'b1;
                            end
                            else if (rxByte != CH_CR || !addrOk_ff)
                                st_ff <= ST_HUNT;
                            else
                            begin
                                st_ff      <= ST_REPLY;
                                txIdx_ff   <= 5'h00;
                                rpyArgs_ff <= 4'h0;
                                if (!(code_ff == CODE_TAB[hit_ff]))
                                    qualOut_ff <= CH_BANG;
                                else if (!isSet_ff)
                                begin
                                    qualOut_ff <= CH_EQ;
                                    rpyArgs_ff <= expLen;
                                end
                                else if (argBad_ff || argN_ff != expLen)
                                    qualOut_ff <= CH_QRY;
                                else if (paramLock)
                                    qualOut_ff <= CH_STAR;
                                else
                                begin
                                    qualOut_ff  <= CH_EQ;
                                    setPulse_ff <= 1'b1;
                                    setIndex_ff <= hit_ff;
                                    for (int i = 0; i < MAX_ARG; i++)
                                        valMem_ff[hit_ff][i] <= argBuf_ff[i];
                                end
                            end
                        end
                        default:  st_ff <= ST_HUNT;
                    endcase
                end
            end
        end
    end
    assign setPulse = setPulse_ff;
    assign setIndex = setIndex_ff;
endmodule
`default_nettype wire

//--- rtl/arph_controller.sv
`timescale 1ns/1ps
`default_nettype none
module arph_fifo
#(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 8
)
(
    input  wire logic             mclk,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic [WIDTH-1:0]      outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ff, rd_ff;
    logic [AW:0]      cnt_ff;
    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
            $error("fifo depth must be a power of two");
    endgenerate
    wire doPush = inValid && inReady;
    wire doPop  = outValid && outReady;
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end
        else
        begin
            if (doPush)
                wr_ff <= wr_ff + 1'b1;
            if (doPop)
                rd_ff <= rd_ff + 1'b1;
            cnt_ff <= cnt_ff + (AW+1)'(doPush) - (AW+1)'(doPop);
        end
    end
    always_ff @(posedge mclk)
    begin
        if (doPush)
            mem_ff[wr_ff] <= inData;
    end
    assign inReady  = (cnt_ff != (AW+1)'(DEPTH));
    assign outValid = (cnt_ff != '0);
    assign outData  = mem_ff[rd_ff];
endmodule

module arph_controller
    import arph_pkg::*;
#(
    parameter int unsigned FIFO_DEPTH = 8,
    parameter int unsigned BITC       = arph_pkg::BIT_CYC
)
(
    input  wire logic       mclk,
    input  wire logic       rstn,
    arph_link_if.ctrlEnd    link,
    input  wire logic [7:0] cmdData,
    input  wire logic       cmdValid,
    output logic            cmdReady,
    output logic [7:0]      rspData,
    output logic            rspValid,
    output logic            rspDone
);
    import arph_pkg::*;
    logic [7:0] qData, rxByte;
    logic       qValid, txReady, txLine, rxValid, fifoReady;
    logic       inPkt_ff, sawCr_ff, rspValid_ff, rspDone_ff, cmdReady_ff;
    logic [7:0] rspData_ff;

    // non-ASCII user bytes are dropped before they can reach the link
    wire cmdOk = (cmdData < CH_LIMIT);
    arph_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) uFifo
    (
        .mclk(mclk), .rstn(rstn), .inData(cmdData), .inValid(cmdValid && cmdOk && cmdReady_ff),
        .inReady(fifoReady), .outData(qData), .outValid(qValid), .outReady(txReady)
    );
    // user bytes start every exchange; this end never answers on its own
    arph_uart_tx #(.BITC(BITC)) uTx (.mclk(mclk), .rstn(rstn), .data(qData), .valid(qValid), .ready(txReady),
                                     .line(txLine));
    arph_uart_rx #(.BITC(BITC)) uRx (.mclk(mclk), .rstn(rstn), .line(link.t2cLine), .data(rxByte),
                                     .valid(rxValid));
    assign link.c2tLine = txLine;

    wire isRspStart = (rxByte == CH_SOP_RSP);
    wire isReqStart = (rxByte == CH_SOP_REQ);
    // ready is registered and drops for one cycle after each push; the fifo itself still refuses when full
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            cmdReady_ff <= 1'b0;
            inPkt_ff    <= 1'b0;
            sawCr_ff    <= 1'b0;
            rspData_ff  <= 8'h00;
            rspValid_ff <= 1'b0;
            rspDone_ff  <= 1'b0;
        end
        else
        begin
            cmdReady_ff <= fifoReady && !(cmdValid && cmdReady_ff && cmdOk);
            rspValid_ff <= 1'b0;
            rspDone_ff  <= 1'b0;
            if (rxValid)
            begin
                if (isRspStart)
                begin
                    inPkt_ff <= 1'b1;
                    sawCr_ff <= 1'b0;
                end
                else if (isReqStart || rxByte >= CH_LIMIT)
                    inPkt_ff <= 1'b0;
                else if (inPkt_ff)
                begin
                    sawCr_ff <= (rxByte == CH_CR);
                    if (sawCr_ff && rxByte == CH_LF)
                    begin
                        inPkt_ff   <= 1'b0;
                        rspDone_ff <= 1'b1;
                    end
                end
                if (isRspStart || (inPkt_ff && !isReqStart && rxByte < CH_LIMIT))
                begin
                    rspData_ff  <= rxByte;
                    rspValid_ff <= 1'b1;
                end
            end
        end
    end
    assign cmdReady = cmdReady_ff;
    assign rspData  = rspData_ff;
    assign rspValid = rspValid_ff;
    assign rspDone  = rspDone_ff;
endmodule
`default_nettype wire

//--- testbench/arph_link_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module arph_link_assertions
    import arph_pkg::*;
#(
    parameter int unsigned BITC = arph_pkg::BIT_CYC
)
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic c2tLine,
    input wire logic t2cLine
);
    import arph_pkg::*;
    localparam int unsigned HALFC = BITC / 2;
    logic [1:0]       lines;
    logic [1:0]       done;
    logic [1:0]       busy_ff;
    logic [1:0][11:0] cnt_ff;
    logic [1:0][3:0]  bit_ff;
    logic [1:0][7:0]  sh_ff;
    logic [7:0]       last_ff;
    logic             first_ff;
    logic             pend_ff;
    assign lines = {t2cLine, c2tLine};
    // byte is whole at mid stop bit
    always_comb
        for (int k = 0; k < 2; k++)
            done[k] = busy_ff[k] && bit_ff[k] == 4'h9 && cnt_ff[k] == 12'(HALFC);
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            busy_ff <= '0;
            cnt_ff <= '0;
            bit_ff <= '0;
            sh_ff <= '0;
        end
        else
            for (int k = 0; k < 2; k++)
                if (!busy_ff[k])
                begin
                    busy_ff[k] <= !lines[k];
                    cnt_ff[k] <= 12'h001;
                    bit_ff[k] <= 4'h0;
                end
                else if (cnt_ff[k] == 12'(BITC - 1))
                begin
                    cnt_ff[k] <= 12'h000;
                    bit_ff[k] <= bit_ff[k] + 4'h1;
                    busy_ff[k] <= bit_ff[k] != 4'h9;
                end
                else
                begin
                    cnt_ff[k] <= cnt_ff[k] + 12'h001;
                    if (cnt_ff[k] == 12'(HALFC) && bit_ff[k] != 4'h0 && bit_ff[k] != 4'h9)
                        sh_ff[k] <= {lines[k], sh_ff[k][7:1]};
                end
    end
    // a reply is owed from a request CR until the reply LF
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            last_ff <= 8'h00;
            first_ff <= 1'b1;
            pend_ff <= 1'b0;
        end
        else
        begin
            if (done[1])
                last_ff <= sh_ff[1];
            if (done[1])
                first_ff <= sh_ff[1] == CH_LF;
            if (done[0] && sh_ff[0] == CH_CR)
                pend_ff <= 1'b1;
            else if (done[1] && sh_ff[1] == CH_LF)
                pend_ff <= 1'b0;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    property p_t2c_start; busy_ff[1] && bit_ff[1] == 4'h0 |-> !t2cLine; endproperty
    a_t2c_start: assert property (p_t2c_start) else $error("reply start bit short");
    property p_t2c_stop; busy_ff[1] && bit_ff[1] == 4'h9 |-> t2cLine; endproperty
    a_t2c_stop: assert property (p_t2c_stop) else $error("reply stop bit low");
    property p_t2c_bit; busy_ff[1] && cnt_ff[1] != 12'h000 |-> $stable(t2cLine); endproperty
    a_t2c_bit: assert property (p_t2c_bit) else $error("reply bit time wrong");
    property p_c2t_bit; busy_ff[0] && cnt_ff[0] != 12'h000 |-> $stable(c2tLine); endproperty
    a_c2t_bit: assert property (p_c2t_bit) else $error("request bit time wrong");
    property p_c2t_stop; busy_ff[0] && bit_ff[0] == 4'h9 |-> c2tLine; endproperty
    a_c2t_stop: assert property (p_c2t_stop) else $error("request stop bit low");
    property p_rsp_sop; done[1] && first_ff |-> sh_ff[1] == CH_SOP_RSP; endproperty
    a_rsp_sop: assert property (p_rsp_sop) else $error("reply start char wrong");
    property p_rsp_char; done[1] |-> sh_ff[1] < CH_LIMIT && sh_ff[1] != CH_SOP_REQ; endproperty
    a_rsp_char: assert property (p_rsp_char) else $error("reply byte illegal");
    property p_rsp_crlf; done[1] && last_ff == CH_CR |-> sh_ff[1] == CH_LF; endproperty
    a_rsp_crlf: assert property (p_rsp_crlf) else $error("reply CR without LF");
    property p_rsp_owed; $fell(t2cLine) && !busy_ff[1] |-> pend_ff; endproperty
    a_rsp_owed: assert property (p_rsp_owed) else $error("target spoke unasked");
    c_req_cr: cover property (done[0] && sh_ff[0] == CH_CR);
    c_reply: cover property ($fell(t2cLine) && !busy_ff[1]);
    c_crlf: cover property (done[1] && sh_ff[1] == CH_LF);
endmodule
`default_nettype wire

//--- testbench/tb_ascii_remote_packet_handler.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module tb_ascii_remote_packet_handler;
    import arph_pkg::*;
    // short bit time keeps the run small; framing and parsing do not depend on it
    localparam int unsigned TB_BITC = 16;
    typedef struct { string rq; string ex; } arph_case_t;
    logic       mclk = 1'b0;
    logic       rstn = 1'b0;
    logic [7:0] cmdData = 8'h00;
    logic       cmdValid = 1'b0;
    logic       paramLock = 1'b0;
    logic       cmdReady;
    logic [7:0] rspData;
    logic       rspValid;
    logic       rspDone;
    logic       setPulse;
    logic [2:0] setIndex;
    logic [2:0] lastIdx;
    logic [7:0] rxq[$];
    int         nSet;
    int         stallCyc;
    int         miscompares;
    int         n_tests;
    arph_case_t tc [6] = '{
        '{"<0001/UAT=12.0\r", ">0001/UAT=\r\n"},
        '{"<0001/UAT?\r", ">0001/UAT=12.0\r\n"},
        '{"<0001/REF=255\r", ">0001/REF*\r\n"},
        '{"<0001/DFQ=12\r", ">0001/DFQ?\r\n"},
        '{"<0001/XYZ?\r", ">0001/XYZ!\r\n"},
        '{"<0002/UAT?\r<0001/UA<0001/DAT?\r", ">0001/DAT=0000\r\n"}
    };
    arph_link_if link ();
    arph_target #(.BITC(TB_BITC)) arph_target_i (
        .mclk      (mclk),
        .rstn      (rstn),
        .link      (link),
        .ownAddr   (32'h3030_3031),
        .paramLock (paramLock),
        .setPulse  (setPulse),
        .setIndex  (setIndex)
    );
    arph_controller #(.FIFO_DEPTH(8), .BITC(TB_BITC)) arph_controller_i (
        .mclk     (mclk),
        .rstn     (rstn),
        .link     (link),
        .cmdData  (cmdData),
        .cmdValid (cmdValid),
        .cmdReady (cmdReady),
        .rspData  (rspData),
        .rspValid (rspValid),
        .rspDone  (rspDone)
    );
    arph_link_assertions #(.BITC(TB_BITC)) arph_link_assertions_i (
        .mclk    (mclk),
        .rstn    (rstn),
        .c2tLine (link.c2tLine),
        .t2cLine (link.t2cLine)
    );
    always #25 mclk = ~mclk;
    always @(negedge mclk)
    begin
        if (rspValid === 1'b1)
            rxq.push_back(rspData);
        if (setPulse === 1'b1)
            lastIdx = setIndex;
        if (setPulse === 1'b1)
            nSet++;
    end
    // long stalls only come from a full buffer behind a slow line
    always @(posedge mclk)
        if (cmdValid && cmdReady !== 1'b1)
            stallCyc++;
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic push(input logic [7:0] b);
        @(negedge mclk);
        cmdValid = 1'b1;
        cmdData = b;
        do @(posedge mclk); while (cmdReady !== 1'b1);
    endtask
    task automatic txn(input string req, input string exp);
        int w;
        rxq.delete();
        foreach (req[i])
            push(8'(req[i]));
        @(negedge mclk);
        cmdValid = 1'b0;
        w = 0;
        while (rspDone !== 1'b1 && w < 8000)
        begin
            @(negedge mclk);
            w++;
        end
        @(negedge mclk);
        `CHK("rspLen", exp.len(), rxq.size())
        foreach (exp[i])
            if (i < rxq.size())
                `CHK("rspByte", 8'(exp[i]), rxq[i])
    endtask
    initial
    begin
        repeat (3) @(negedge mclk);
        rstn = 1'b1;
        repeat (2) @(negedge mclk);
        for (int i = 0; i < 6; i++)
        begin
            paramLock = 1'(i == 2);
            txn(tc[i].rq, tc[i].ex);
            $display("test %0d done", i);
        end
        `CHK("setCount", 1, nSet)
        `CHK("setIndex", 3'h2, lastIdx)
        `CHK("fifoFull", 1'b1, 1'(stallCyc > 1000))
        complete_run();
    end
    initial
    begin
        // about 175 bytes at 161 cycles each, with room to spare
        repeat (60000) @(posedge mclk);
        miscompares++;
        complete_run();
    end
endmodule
`default_nettype wire
